// ---- hdl/keypad_pkg.sv ----
// Constants shared by the keypad pin interrupt unit
package keypad_pkg;
    localparam int          PIN_COUNT         = 6;
    localparam int          ADDR_WIDTH        = 8;
    localparam int          DATA_WIDTH        = 32;
    localparam int          REG_WIDTH         = 8;

    // Register byte addresses on the bus
    localparam logic [7:0]  STATUS_CTRL_ADDR  = 8'h00;
    localparam logic [7:0]  PIN_ENABLE_ADDR   = 8'h04;

    // Status and control field positions
    localparam int          SENS_SELECT_BIT   = 0;
    localparam int          REQ_MASK_BIT      = 1;
    localparam int          REQ_ACK_BIT       = 2;
    localparam int          PENDING_FLAG_BIT  = 3;

    // Pin enable field positions
    localparam int          PIN_ENABLE_LSB    = 0;
    localparam int          WAKE_ENABLE_BIT   = 6;

    // Reset values
    localparam logic [7:0]  STATUS_CTRL_RESET = 8'h00;
    localparam logic [7:0]  PIN_ENABLE_RESET  = 8'h00;
    localparam logic [5:0]  PIN_MASK_RESET    = 6'h00;

    // Vector locations of the keypad request, high byte first
    localparam logic [15:0] VECTOR_HIGH_ADDR  = 16'hFFE0;
    localparam logic [15:0] VECTOR_LOW_ADDR   = 16'hFFE1;

    // Bus answer latency in cycles of penable before pready
    localparam int          BUS_WAIT_CYCLES   = 1;
endpackage : keypad_pkg

// ---- hdl/keypad_pin_interrupt.sv ----
// Keypad pin interrupt unit with APB register access
// Overview of operation
// [R1] Six independent pin enable bits
// [R2] Enabled pin forces its pullup on
// [R3] Latch request when enabled input falls, all high
// [R4] Edge mode: no latch while another low
// [R5] Level mode: request holds while input low
// [R6] Select bit: 1 edge-level, 0 edge only
// [R7] Level mode clear needs ack and release
// [R8] Acknowledge by vector fetch or ack write
// [R9] Edge after ack write latches new request
// [R10] Unmasked request fetches vector at fixed locations
// [R11] Wakeup request cleared by ack write, reset
// [R12] Edge mode: acknowledge clears latch at once
// [R13] Reset clears latch and select bit
// [R14] Pending flag shows requests, ignores mask
// [R15] Enable forces pin input, overrides direction
// [R16] Software: mask, enable, ack, then unmask
// [R17] Software: drive pins high before enabling
// [R18] Active in wait, stop; wakes when unmasked
// [R19] Break state blocks ack unless clear enabled
// [R20] Upper status bits and ack read zero
// [R21] Mask blocks CPU request, reset clears mask
// [R22] Reset clears all pin enables
// [R23] Falling edge is high sample then low
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module keypad_pin_interrupt (
    input  wire logic                                sys_clk,
    input  wire logic                                rst_b,
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [keypad_pkg::ADDR_WIDTH-1:0]   paddr,
    input  wire logic [keypad_pkg::DATA_WIDTH-1:0]   pwdata,
    output logic      [keypad_pkg::DATA_WIDTH-1:0]   prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    input  wire logic [keypad_pkg::PIN_COUNT-1:0]    portPins,
    input  wire logic [keypad_pkg::PIN_COUNT-1:0]    portDirection,
    input  wire logic [keypad_pkg::PIN_COUNT-1:0]    portPullupEnable,
    input  wire logic                                wakeupRequestIn,
    input  wire logic                                vectorFetch,
    input  wire logic                                breakState,
    input  wire logic                                breakClearEnable,
    output logic                                     cpuIrqReq,
    output logic                                     wakeFromLowPower,
    output logic      [keypad_pkg::PIN_COUNT-1:0]    pullupOn,
    output logic      [keypad_pkg::PIN_COUNT-1:0]    directionOut
);

    // Register state
    logic [keypad_pkg::PIN_COUNT-1:0] pinEnable_reg;
    logic                             wakeEnable_reg;
    logic                             sensSelect_reg;
    logic                             reqMask_reg;
    logic                             pinLatch_reg;
    logic                             pinLatch_next;
    logic                             wakeLatch_reg;
    logic                             wakeLatch_next;
    logic                             ackSeen_reg;
    logic                             ackSeen_next;
    logic                             pendingFlag_reg;
    logic                             cpuIrq_reg;
    logic                             wake_reg;
    logic [keypad_pkg::PIN_COUNT-1:0] pinSample_reg;
    logic                             wakeSample_reg;
    logic                             wakePrev_reg;
    logic                             anyLowPrev_reg;
    logic [keypad_pkg::PIN_COUNT-1:0] pullup_reg;
    logic [keypad_pkg::PIN_COUNT-1:0] direction_reg;
    logic [keypad_pkg::DATA_WIDTH-1:0] rdata_reg;
    logic                             ready_reg;
    logic                             slvErr_reg;

    // Bus decode
    logic                             accessPhase;
    logic                             accessDone;
    logic                             hitStatus;
    logic                             hitEnable;
    logic                             ackWrite;
    logic                             ackAllowed;
    logic                             ackEvent;
    logic                             anyPinLow;
    logic                             pinEdge;
    logic                             wakeRise;

    function automatic logic addrHit(
        input logic [keypad_pkg::ADDR_WIDTH-1:0] addr,
        input logic [keypad_pkg::ADDR_WIDTH-1:0] target
    );
        addrHit = (addr == target);
    endfunction : addrHit

    assign accessPhase = psel && penable;
    // A write lands only on the edge where pready is seen high
    assign accessDone  = accessPhase && ready_reg;
    assign hitStatus   = addrHit(paddr, keypad_pkg::STATUS_CTRL_ADDR);
    assign hitEnable   = addrHit(paddr, keypad_pkg::PIN_ENABLE_ADDR);

    // Break state blocks ack writes unless clearing is allowed; vector fetches still acknowledge
    assign ackAllowed  = !breakState || breakClearEnable;           // [R19]
    assign ackWrite    = accessDone && pwrite && hitStatus
                         && pwdata[keypad_pkg::REQ_ACK_BIT]
                         && ackAllowed;                             // [R8]
    assign ackEvent    = ackWrite || vectorFetch;                   // [R8]

    // Only enabled pins take part in the low detection
    assign anyPinLow   = |(~pinSample_reg & pinEnable_reg);         // [R1]
    // All high last sample, some low now: that alone is an edge
    assign pinEdge     = anyPinLow && !anyLowPrev_reg;           // [R3] [R4]
    assign wakeRise    = wakeSample_reg && !wakePrev_reg && wakeEnable_reg;

    // Input sampling on the bus clock
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pinSample_reg  <= {keypad_pkg::PIN_COUNT{1'b1}};
            wakeSample_reg <= 1'b0;
            wakePrev_reg   <= 1'b0;
            anyLowPrev_reg <= 1'b0;
        end else begin
            pinSample_reg  <= portPins;                             // [R23]
            wakeSample_reg <= wakeupRequestIn;
            wakePrev_reg   <= wakeSample_reg;
            anyLowPrev_reg <= anyPinLow;                            // [R23]
        end
    end

    // Pin request latch; a new edge wins over any clear
    always_comb begin
        pinLatch_next = pinLatch_reg;
        ackSeen_next  = ackSeen_reg;
        if (pinEdge) begin
            pinLatch_next = 1'b1;                                   // [R3] [R9]
            ackSeen_next  = 1'b0;                                   // [R9]
        end else if (pinLatch_reg) begin
            if (!sensSelect_reg) begin
                if (ackEvent) begin
                    pinLatch_next = 1'b0;                           // [R12]
                end
                ackSeen_next = 1'b0;
            end else if ((ackEvent || ackSeen_reg) && !anyPinLow) begin
                pinLatch_next = 1'b0;                               // [R7]
                ackSeen_next  = 1'b0;
            end else begin
                // Held while any enabled pin stays low
                ackSeen_next = ackSeen_reg || ackEvent;          // [R5] [R7]
            end
        end else begin
            ackSeen_next = 1'b0;
        end
    end

    // Wakeup request ignores vector fetches; only an ack write or reset clears it
    always_comb begin
        wakeLatch_next = wakeLatch_reg;
        if (wakeRise) begin
            wakeLatch_next = 1'b1;
        end else if (ackWrite) begin
            wakeLatch_next = 1'b0;                                  // [R11]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pinLatch_reg  <= 1'b0;                                  // [R13]
            ackSeen_reg   <= 1'b0;
            wakeLatch_reg <= 1'b0;                                  // [R11]
        end else begin
            pinLatch_reg  <= pinLatch_next;
            ackSeen_reg   <= ackSeen_next;
            wakeLatch_reg <= wakeLatch_next;
        end
    end

    // Flag and CPU request follow the latch next values so all agree
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pendingFlag_reg <= 1'b0;                                // [R14]
            cpuIrq_reg      <= 1'b0;
            wake_reg        <= 1'b0;
        end else begin
            pendingFlag_reg <= pinLatch_next || wakeLatch_next;     // [R14]
            // CPU then fetches the vector at the fixed locations
            cpuIrq_reg      <= (pinLatch_next || wakeLatch_next)
                               && !reqMask_reg;                   // [R10] [R21]
            // No clock gating here, so the unit keeps running in stop
            wake_reg        <= (pinLatch_next || wakeLatch_next)
                               && !reqMask_reg;                     // [R18]
        end
    end

    // Control register writes
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sensSelect_reg <= keypad_pkg::STATUS_CTRL_RESET[
                                  keypad_pkg::SENS_SELECT_BIT];     // [R13]
            reqMask_reg    <= keypad_pkg::STATUS_CTRL_RESET[
                                  keypad_pkg::REQ_MASK_BIT];        // [R21]
        end else if (accessDone && pwrite && hitStatus) begin
            sensSelect_reg <= pwdata[keypad_pkg::SENS_SELECT_BIT];  // [R6]
            reqMask_reg    <= pwdata[keypad_pkg::REQ_MASK_BIT];     // [R21]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pinEnable_reg  <= keypad_pkg::PIN_MASK_RESET;           // [R22]
            wakeEnable_reg <= keypad_pkg::PIN_ENABLE_RESET[
                                  keypad_pkg::WAKE_ENABLE_BIT];     // [R22]
        end else if (accessDone && pwrite && hitEnable) begin
            pinEnable_reg  <= pwdata[keypad_pkg::PIN_ENABLE_LSB +:
                                     keypad_pkg::PIN_COUNT];        // [R1]
            wakeEnable_reg <= pwdata[keypad_pkg::WAKE_ENABLE_BIT];
        end
    end

    // Pin overrides toward the port logic
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pullup_reg    <= keypad_pkg::PIN_MASK_RESET;
            direction_reg <= keypad_pkg::PIN_MASK_RESET;
        end else begin
            pullup_reg    <= portPullupEnable | pinEnable_reg;      // [R2]
            // 1 means output; an enabled pin is forced to input
            direction_reg <= portDirection & ~pinEnable_reg;        // [R15]
        end
    end

    // Bus answer: one wait state, data prepared with pready
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ready_reg  <= 1'b0;
            slvErr_reg <= 1'b0;
            rdata_reg  <= '0;
        end else begin
            ready_reg  <= accessPhase && !ready_reg;
            slvErr_reg <= accessPhase && !ready_reg
                          && !hitStatus && !hitEnable;
            rdata_reg  <= '0;
            if (accessPhase && !ready_reg && !pwrite) begin
                if (hitStatus) begin
                    // Ack and bits 7-4 stay zero
                    rdata_reg[keypad_pkg::PENDING_FLAG_BIT] <=
                        pendingFlag_reg;                            // [R20]
                    rdata_reg[keypad_pkg::REQ_MASK_BIT]     <=
                        reqMask_reg;
                    rdata_reg[keypad_pkg::SENS_SELECT_BIT]  <=
                        sensSelect_reg;                             // [R6]
                end else if (hitEnable) begin
                    rdata_reg[keypad_pkg::PIN_ENABLE_LSB +:
                              keypad_pkg::PIN_COUNT] <= pinEnable_reg;
                    rdata_reg[keypad_pkg::WAKE_ENABLE_BIT] <=
                        wakeEnable_reg;
                end
            end
        end
    end

    assign prdata           = rdata_reg;
    assign pready           = ready_reg;
    assign pslverr          = slvErr_reg;
    assign cpuIrqReq        = cpuIrq_reg;
    assign wakeFromLowPower = wake_reg;
    assign pullupOn         = pullup_reg;
    assign directionOut     = direction_reg;

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    sequence ackInLevel;
        sensSelect_reg && pinLatch_reg && ackEvent && anyPinLow && !pinEdge;
    endsequence

    sequence releaseNoEdge;
        !anyPinLow && !pinEdge;
    endsequence

    AST_EDGE_LATCH: assert property (                             // [R3]
        pinEdge |=> pinLatch_reg && pendingFlag_reg)
        else $error("edge did not latch a request");

    AST_EDGE_ONLY_BLOCKED: assert property (                      // [R4]
        (!pinLatch_reg && anyLowPrev_reg && !wakeRise) |=>
            !pinLatch_reg)
        else $error("latch set while an input was already low");

    AST_LEVEL_HOLDS: assert property (                            // [R5]
        (sensSelect_reg && pinLatch_reg && anyPinLow) |=> pinLatch_reg)
        else $error("level request dropped while input low");

    AST_LEVEL_CLEAR_ANY_ORDER: assert property (                  // [R7]
        (sensSelect_reg && pinLatch_reg && ackSeen_reg) ##0 releaseNoEdge
            |=> !pinLatch_reg)
        else $error("level request not cleared after ack and release");

    AST_LEVEL_ACK_HELD: assert property (                         // [R5] [R7]
        ackInLevel |=> pinLatch_reg && ackSeen_reg)
        else $error("level request dropped on ack while input low");

    AST_RELEASE_ACK_CLEARS: assert property (                     // [R7]
        (sensSelect_reg && pinLatch_reg && ackEvent) ##0 releaseNoEdge
            |=> !pinLatch_reg)
        else $error("ack after release did not clear level request");

    AST_EDGE_ACK_CLEARS: assert property (                        // [R12]
        (!sensSelect_reg && pinLatch_reg && ackEvent && !pinEdge)
            |=> !pinLatch_reg)
        else $error("edge mode acknowledge did not clear latch");

    AST_WAKE_FETCH_KEEPS: assert property (                       // [R11]
        (wakeLatch_reg && !ackWrite) |=> wakeLatch_reg)
        else $error("wakeup request cleared without ack write");

    AST_BREAK_PROTECT: assert property (                          // [R19]
        (breakState && !breakClearEnable && !vectorFetch
            && pinLatch_reg && !ackSeen_reg) |=> pinLatch_reg)
        else $error("ack write acted during protected break");

    AST_FLAG_MATCH: assert property (                             // [R14]
        pendingFlag_reg == (pinLatch_reg || wakeLatch_reg))
        else $error("pending flag disagrees with latches");

    AST_MASK_BLOCKS: assert property (                            // [R21]
        reqMask_reg |=> !cpuIrqReq)
        else $error("masked request reached the CPU");

    AST_READ_ZERO: assert property (                              // [R20]
        (accessDone && !pwrite && hitStatus) |->
            (prdata[7:4] == 4'h0 && !prdata[keypad_pkg::REQ_ACK_BIT]))
        else $error("reserved or ack bits read nonzero");

    AST_FORCED_INPUT: assert property (                           // [R15]
        $past(pinEnable_reg) != 6'h00 |->
            (directionOut & $past(pinEnable_reg)) == 6'h00)
        else $error("enabled pin left as output");

    AST_PULLUP_ON: assert property (                              // [R2]
        ##1 ((pullupOn & $past(pinEnable_reg)) == $past(pinEnable_reg)))
        else $error("enabled pin pullup off");

    // Extra checks of both latch set paths, the wakeup clear, the request outputs and the select write
    AST_NO_EDGE_NO_SET: assert property (                         // [R3]
        (!pinLatch_reg && !pinEdge) |=> !pinLatch_reg)
        else $error("pin request latched without an edge");

    AST_WAKE_RISE_LATCH: assert property (                        // [R14]
        wakeRise |=> wakeLatch_reg && pendingFlag_reg)
        else $error("wakeup rise did not latch a request");

    AST_ACK_CLEARS_WAKE: assert property (                        // [R11]
        (ackWrite && !wakeRise) |=> !wakeLatch_reg)
        else $error("ack write left wakeup request set");

    AST_UNMASKED_REQ: assert property (                          // [R10] [R21]
        (pendingFlag_reg && !$past(reqMask_reg)) |-> cpuIrqReq)
        else $error("unmasked pending request not sent to the CPU");

    AST_WAKE_FOLLOWS_IRQ: assert property (                       // [R18]
        wakeFromLowPower == cpuIrqReq)
        else $error("wake output disagrees with CPU request");

    AST_SELECT_WRITE: assert property (                           // [R6]
        (accessDone && pwrite && hitStatus) |=>
            sensSelect_reg == $past(pwdata[keypad_pkg::SENS_SELECT_BIT]))
        else $error("sensitivity select write not taken");

endmodule : keypad_pin_interrupt

`default_nettype wire

// ---- verification/keypad_switch_model.sv ----
// Keypad switch lines seen at the port pins, with pullup behaviour
`timescale 1ns/1ps
`default_nettype none

module keypad_switch_model (
    input  wire logic                             sys_clk,
    input  wire logic [keypad_pkg::PIN_COUNT-1:0] pullupOn,
    input  wire logic [keypad_pkg::PIN_COUNT-1:0] pressMask,
    input  wire logic [keypad_pkg::PIN_COUNT-1:0] outHigh,
    output logic      [keypad_pkg::PIN_COUNT-1:0] portPins
);
    // An undriven line without pullup must not settle to a friendly value
    logic [keypad_pkg::PIN_COUNT-1:0] floatPattern = 6'h2A;

    always @(posedge sys_clk) begin
        floatPattern <= ~floatPattern;
    end

    // A closed switch pulls the line low; an open one follows the pullup
    always_comb begin
        for (int i = 0; i < keypad_pkg::PIN_COUNT; i++) begin
            if (pressMask[i]) begin
                portPins[i] = 1'b0;
            end else if (pullupOn[i] || outHigh[i]) begin
                // Output pins are driven at 1 by the port data
                portPins[i] = 1'b1;
            end else begin
                portPins[i] = floatPattern[i];
            end
        end
    end
endmodule : keypad_switch_model

`default_nettype wire

// ---- verification/keypad_pin_interrupt_tb.sv ----
// Self-checking bench for the keypad pin interrupt unit
`timescale 1ns/1ps
`default_nettype none

module keypad_pin_interrupt_tb;
    localparam logic [5:0] EN = 6'h3D;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rdv;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic [5:0]  portPins;
    logic [5:0]  portDirection = 6'h00;
    logic [5:0]  portPullupEnable = 6'h00;
    logic [5:0]  pressMask = 6'h00;
    logic [5:0]  pullupOn;
    logic [5:0]  directionOut;
    logic        wakeupRequestIn = 1'b0;
    logic        vectorFetch = 1'b0;
    logic        breakState = 1'b0;
    logic        breakClearEnable = 1'b0;
    logic        cpuIrqReq;
    logic        wakeFromLowPower;
    logic        mode = 1'b0;
    logic        mask = 1'b0;
    int          num_errors = 0;
    int          comparisons = 0;
    int          seed = 42;
    int          k;

    always #2.5 sys_clk = ~sys_clk;

    keypad_pin_interrupt i_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .portPins(portPins),
        .portDirection(portDirection), .portPullupEnable(portPullupEnable),
        .wakeupRequestIn(wakeupRequestIn), .vectorFetch(vectorFetch),
        .breakState(breakState), .breakClearEnable(breakClearEnable),
        .cpuIrqReq(cpuIrqReq), .wakeFromLowPower(wakeFromLowPower),
        .pullupOn(pullupOn), .directionOut(directionOut)
    );

    keypad_switch_model i_keys (
        .sys_clk(sys_clk), .pullupOn(pullupOn), .pressMask(pressMask),
        .outHigh(directionOut), .portPins(portPins)
    );

    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task finish_test();
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    task tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick

    // Holds the request until pready is seen high at a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] rd, output logic er);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            finish_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [31:0] scr(input logic ack, input logic flag);
        scr = (32'(mode) << keypad_pkg::SENS_SELECT_BIT)
            | (32'(mask) << keypad_pkg::REQ_MASK_BIT)
            | (32'(ack) << keypad_pkg::REQ_ACK_BIT)
            | (32'(flag) << keypad_pkg::PENDING_FLAG_BIT);
    endfunction : scr

    function automatic int pick();
        int p;
        p = {$random(seed)} % 6;
        pick = (p == 1) ? 0 : p;
    endfunction : pick

    task wscr(input logic ack);
        apb(1'b1, keypad_pkg::STATUS_CTRL_ADDR, scr(ack, 1'b0), rdv, err);
    endtask : wscr

    task rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rdv, err);
        check(rdv, exp);
    endtask : rchk

    task press(input logic [5:0] m);
        @(posedge sys_clk);
        pressMask <= m;
    endtask : press

    task fetch();
        @(posedge sys_clk);
        vectorFetch <= 1'b1;
        @(posedge sys_clk);
        vectorFetch <= 1'b0;
    endtask : fetch

    // Pending flag ignores the mask; both request outputs honour it
    task pend(input logic flag);
        tick(3);
        rchk(keypad_pkg::STATUS_CTRL_ADDR, scr(1'b0, flag));
        check(32'({cpuIrqReq, wakeFromLowPower}),
              {30'h0, {2{flag & ~mask}}});
    endtask : pend

    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        finish_test();
    end

    initial begin
        tick(16);
        rst_b <= 1'b1;
        portDirection <= 6'($random(seed));
        portPullupEnable <= 6'($random(seed));
        rchk(keypad_pkg::STATUS_CTRL_ADDR, 32'h0);
        rchk(keypad_pkg::PIN_ENABLE_ADDR, 32'h0);
        apb(1'b0, 8'h08, 32'h0, rdv, err);
        check(rdv, 32'h0);
        check(32'(err), 32'h1);
        mask = 1'b1;
        wscr(1'b0);
        apb(1'b1, keypad_pkg::PIN_ENABLE_ADDR, 32'(EN), rdv, err);
        wscr(1'b1);
        mask = 1'b0;
        wscr(1'b0);
        rchk(keypad_pkg::PIN_ENABLE_ADDR, 32'(EN));
        check(32'(pullupOn), 32'(portPullupEnable | EN));
        check(32'(directionOut), 32'(portDirection & ~EN));
        pend(1'b0);
        repeat (6) begin
            k = pick();
            press(6'h01 << k);
            pend(1'b1);
            fetch();
            pend(1'b0);
            press(EN);
            pend(1'b0);
            press(6'h00);
            pend(1'b0);
        end
        wscr(1'b1);
        press(6'h01 << k);
        pend(1'b1);
        wscr(1'b1);
        pend(1'b0);
        press(6'h00);
        mask = 1'b1;
        wscr(1'b0);
        press(6'h01 << k);
        pend(1'b1);
        wscr(1'b1);
        press(6'h00);
        mask = 1'b0;
        wscr(1'b0);
        pend(1'b0);
        mode = 1'b1;
        wscr(1'b0);
        rchk(keypad_pkg::STATUS_CTRL_ADDR, scr(1'b0, 1'b0));
        press(6'h01 << k);
        pend(1'b1);
        fetch();
        pend(1'b1);
        press(6'h00);
        pend(1'b0);
        press(6'h01 << k);
        press(6'h00);
        pend(1'b1);
        wscr(1'b1);
        pend(1'b0);
        @(posedge sys_clk);
        breakState <= 1'b1;
        press(6'h01 << k);
        press(6'h00);
        wscr(1'b1);
        pend(1'b1);
        breakClearEnable <= 1'b1;
        wscr(1'b1);
        breakState <= 1'b0;
        breakClearEnable <= 1'b0;
        pend(1'b0);
        mode = 1'b0;
        wscr(1'b0);
        apb(1'b1, keypad_pkg::PIN_ENABLE_ADDR,
            32'(EN) | (32'h1 << keypad_pkg::WAKE_ENABLE_BIT), rdv, err);
        @(posedge sys_clk);
        wakeupRequestIn <= 1'b1;
        @(posedge sys_clk);
        wakeupRequestIn <= 1'b0;
        pend(1'b1);
        fetch();
        pend(1'b1);
        wscr(1'b1);
        pend(1'b0);
        mode = 1'b1;
        wscr(1'b0);
        press(6'h01 << k);
        pend(1'b1);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        tick(2);
        rst_b <= 1'b1;
        mode = 1'b0;
        pend(1'b0);
        rchk(keypad_pkg::PIN_ENABLE_ADDR, 32'h0);
        press(6'h00);
        // Pins held as outputs at 1 while enabling: no false request
        portDirection <= 6'h3F;
        tick(3);
        apb(1'b1, keypad_pkg::PIN_ENABLE_ADDR, 32'(EN), rdv, err);
        pend(1'b0);
        check(32'(directionOut), 32'(6'h3F & ~EN));
        finish_test();
    end
endmodule : keypad_pin_interrupt_tb

`default_nettype wire
